// ### verilog/obcd_pkg.sv
// Package for the option byte configuration decoder: layout, defaults, states
// Summary of operation
// - Option bytes are read or written only on requests in programming mode; a protected erase already started completes even outside it.
// - Byte one bits 7:6 pick start-up clock: internal RC, wake-up RC, reserved, external pin.
// - Default option byte contents start the device from the internal RC oscillator.
// - Byte one bits 3:2 set detector: 11 off, 10 high, 01 medium, 00 low.
// - Byte one bit 1: 0 watchdog always on by hardware, 1 enabled by software.
// - Byte one bit 0: 1 resets on halt entry with watchdog active, 0 does not.
// - Byte zero bit 2 sets sector 0 size: 0 half kilobyte, 1 one kilobyte.
// - Byte zero bit 1 set blocks read-out of program memory and flash writes.
// - Erasing option bytes under read-out protection first erases all program memory.
// - Byte zero bit 0 set makes program memory and that bit permanently locked.
// - Program memory is delivered erased, every byte holding all ones.
package obcd_pkg;

  // Reset (default) contents of the two option bytes
  localparam logic [7:0] CFG1_RESET      = 8'h2f;
  localparam logic [7:0] CFG0_RESET      = 8'hf0;
  // Erased value of every program memory byte
  localparam logic [7:0] PROG_MEM_ERASED = 8'hff;

  // Byte one field positions
  localparam int STARTUP_CLK_MSB = 7;
  localparam int STARTUP_CLK_LSB = 6;
  localparam int DET_MSB         = 3;
  localparam int DET_LSB         = 2;
  localparam int WDOG_TYPE_BIT   = 1;
  localparam int WDOG_HALT_BIT   = 0;
  // Byte zero field positions
  localparam int SECTOR0_BIT = 2;
  localparam int ROP_BIT     = 1;
  localparam int WP_BIT      = 0;

  // Start-up clock codes
  localparam logic [1:0] CLK_INT_RC   = 2'h0;
  localparam logic [1:0] CLK_WAKE_RC  = 2'h1;
  localparam logic [1:0] CLK_RESERVED = 2'h2;
  localparam logic [1:0] CLK_EXT_PIN  = 2'h3;

  // Detector threshold codes
  localparam logic [1:0] DET_LOWEST  = 2'h0;
  localparam logic [1:0] DET_MEDIUM  = 2'h1;
  localparam logic [1:0] DET_HIGHEST = 2'h2;
  localparam logic [1:0] DET_OFF     = 2'h3;

  typedef enum logic [1:0] {
    OBCD_LOAD,
    OBCD_RUN,
    OBCD_MEM_ERASE
  } obcd_state_t;

  typedef struct packed {
    obcd_state_t state;
    logic [7:0]  cfg0;
    logic [7:0]  cfg1;
    logic [7:0]  rdata;
    logic        ack;
    logic        refused;
    logic        nv_wr;
    logic        nv_sel;
    logic [7:0]  nv_data;
    logic        nv_opt_erase;
    logic        mem_erase_req;
    logic [7:0]  mem_fill;
    logic        valid;
    logic        wr_block;
  } obcd_regs_t;

endpackage : obcd_pkg

// ### verilog/obcd_option_decoder.sv
// Option byte holder, programming access port and configuration decoder
`timescale 1ns/10ps
`default_nettype none

module obcd_option_decoder (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       prog_mode,
  input  wire logic       prog_rd,
  input  wire logic       prog_wr,
  input  wire logic       prog_erase,
  input  wire logic       prog_sel,
  input  wire logic [7:0] prog_wdata,
  input  wire logic [7:0] nv_byte0,
  input  wire logic [7:0] nv_byte1,
  input  wire logic       mem_erase_done,
  output logic      [7:0] prog_rdata,
  output logic            prog_ack,
  output logic            prog_refused,
  output logic            nv_wr_strobe,
  output logic            nv_wr_sel,
  output logic      [7:0] nv_wr_data,
  output logic            nv_opt_erase,
  output logic            mem_erase_req,
  output logic      [7:0] mem_erase_fill,
  output logic            config_valid,
  output logic      [1:0] startup_clock_select,
  output logic      [1:0] low_voltage_detect_threshold,
  output logic            watchdog_type_select,
  output logic            watchdog_halt_reset,
  output logic            sector_zero_size,
  output logic            readout_protect,
  output logic            flash_write_protect,
  output logic            flash_write_block
);

  obcd_pkg::obcd_regs_t ob_reg;
  obcd_pkg::obcd_regs_t ob_next;

  // Picks one of the two option bytes
  function automatic logic [7:0] pick_byte(input logic sel, input logic [7:0] b0, input logic [7:0] b1);
    pick_byte = sel ? b1 : b0;
  endfunction : pick_byte

  always_comb
  begin
    ob_next              = ob_reg;
    ob_next.ack          = 1'b0;
    ob_next.refused      = 1'b0;
    ob_next.nv_wr        = 1'b0;
    ob_next.nv_opt_erase = 1'b0;
    ob_next.mem_fill     = obcd_pkg::PROG_MEM_ERASED;
    case (ob_reg.state)
      obcd_pkg::OBCD_LOAD:
      begin
        // Stored bytes are captured right after reset release
        ob_next.cfg0  = nv_byte0;
        ob_next.cfg1  = nv_byte1;
        ob_next.valid = 1'b1;
        ob_next.state = obcd_pkg::OBCD_RUN;
      end
      obcd_pkg::OBCD_RUN:
      begin
        if (!prog_mode)
        begin
          // Normal mode: requests ignored, read data held at zero
          ob_next.rdata = 8'h00;
        end
        else if (prog_erase)
        begin
          if (ob_reg.cfg0[obcd_pkg::WP_BIT])
          begin
            ob_next.refused = 1'b1;
          end
          else if (ob_reg.cfg0[obcd_pkg::ROP_BIT])
          begin
            ob_next.mem_erase_req = 1'b1;
            ob_next.state         = obcd_pkg::OBCD_MEM_ERASE;
          end
          else
          begin
            ob_next.cfg0         = obcd_pkg::CFG0_RESET;
            ob_next.cfg1         = obcd_pkg::CFG1_RESET;
            ob_next.nv_opt_erase = 1'b1;
            ob_next.ack          = 1'b1;
          end
        end
        else if (prog_wr)
        begin
          if (ob_reg.cfg0[obcd_pkg::WP_BIT])
          begin
            ob_next.refused = 1'b1;
          end
          else
          begin
            // The programmer keeps the reserved bits at their fixed values
            if (prog_sel)
            begin
              ob_next.cfg1 = prog_wdata;
            end
            else
            begin
              ob_next.cfg0 = prog_wdata;
            end
            ob_next.nv_wr   = 1'b1;
            ob_next.nv_sel  = prog_sel;
            ob_next.nv_data = prog_wdata;
            ob_next.ack     = 1'b1;
          end
        end
        else if (prog_rd)
        begin
          ob_next.rdata = pick_byte(prog_sel, ob_reg.cfg0, ob_reg.cfg1);
          ob_next.ack   = 1'b1;
        end
      end
      obcd_pkg::OBCD_MEM_ERASE:
      begin
        if (!prog_mode)
        begin
          ob_next.rdata = 8'h00;
        end
        // Option bytes go back to defaults only once memory is wiped
        if (mem_erase_done)
        begin
          ob_next.mem_erase_req = 1'b0;
          ob_next.cfg0          = obcd_pkg::CFG0_RESET;
          ob_next.cfg1          = obcd_pkg::CFG1_RESET;
          ob_next.nv_opt_erase  = 1'b1;
          ob_next.ack           = 1'b1;
          ob_next.state         = obcd_pkg::OBCD_RUN;
        end
      end
      default:
      begin
        ob_next.state = obcd_pkg::OBCD_LOAD;
      end
    endcase
    // Either protection refuses flash writes; follows byte zero in the same cycle
    ob_next.wr_block = ob_next.cfg0[obcd_pkg::ROP_BIT] | ob_next.cfg0[obcd_pkg::WP_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ob_reg.state         <= obcd_pkg::OBCD_LOAD;
      ob_reg.cfg0          <= obcd_pkg::CFG0_RESET;
      ob_reg.cfg1          <= obcd_pkg::CFG1_RESET;
      ob_reg.rdata         <= 8'h00;
      ob_reg.ack           <= 1'b0;
      ob_reg.refused       <= 1'b0;
      ob_reg.nv_wr         <= 1'b0;
      ob_reg.nv_sel        <= 1'b0;
      ob_reg.nv_data       <= 8'h00;
      ob_reg.nv_opt_erase  <= 1'b0;
      ob_reg.mem_erase_req <= 1'b0;
      ob_reg.mem_fill      <= obcd_pkg::PROG_MEM_ERASED;
      ob_reg.valid         <= 1'b0;
      ob_reg.wr_block      <= 1'b0;
    end
    else
    begin
      ob_reg <= ob_next;
    end
  end

  assign prog_rdata                   = ob_reg.rdata;
  assign prog_ack                     = ob_reg.ack;
  assign prog_refused                 = ob_reg.refused;
  assign nv_wr_strobe                 = ob_reg.nv_wr;
  assign nv_wr_sel                    = ob_reg.nv_sel;
  assign nv_wr_data                   = ob_reg.nv_data;
  assign nv_opt_erase                 = ob_reg.nv_opt_erase;
  assign mem_erase_req                = ob_reg.mem_erase_req;
  assign mem_erase_fill               = ob_reg.mem_fill;
  assign config_valid                 = ob_reg.valid;
  assign startup_clock_select         = ob_reg.cfg1[obcd_pkg::STARTUP_CLK_MSB:obcd_pkg::STARTUP_CLK_LSB];
  assign low_voltage_detect_threshold = ob_reg.cfg1[obcd_pkg::DET_MSB:obcd_pkg::DET_LSB];
  assign watchdog_type_select         = ob_reg.cfg1[obcd_pkg::WDOG_TYPE_BIT];
  assign watchdog_halt_reset          = ob_reg.cfg1[obcd_pkg::WDOG_HALT_BIT];
  assign sector_zero_size             = ob_reg.cfg0[obcd_pkg::SECTOR0_BIT];
  assign readout_protect              = ob_reg.cfg0[obcd_pkg::ROP_BIT];
  assign flash_write_protect          = ob_reg.cfg0[obcd_pkg::WP_BIT];
  assign flash_write_block            = ob_reg.wr_block;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_run_req;
    ob_reg.state == obcd_pkg::OBCD_RUN && prog_mode && !prog_erase;
  endsequence
  sequence s_wr_one;
    s_run_req ##0 prog_wr && prog_sel && !flash_write_protect;
  endsequence
  sequence s_wr_zero;
    s_run_req ##0 prog_wr && !prog_sel && !flash_write_protect;
  endsequence

  a_normal_no_ack: assert property (
    ob_reg.state == obcd_pkg::OBCD_RUN && !prog_mode |=> !prog_ack && !nv_wr_strobe && prog_rdata == 8'h00)
    else $error("request taken outside programming mode");
  a_read_path: assert property (
    s_run_req ##0 !prog_wr && prog_rd
      |=> prog_ack && prog_rdata == ($past(prog_sel) ? $past(ob_reg.cfg1) : $past(ob_reg.cfg0)))
    else $error("read returned wrong option byte");
  a_clock_decode: assert property (
    s_wr_one |=> startup_clock_select == $past(prog_wdata[7:6]) ##1 $stable(startup_clock_select) || prog_mode)
    else $error("start-up clock field not decoded");
  a_reset_default: assert property (
    $fell(rst) |-> startup_clock_select == obcd_pkg::CLK_INT_RC && !config_valid)
    else $error("reset does not select internal RC");
  a_lvd_decode: assert property (
    s_wr_one |=> low_voltage_detect_threshold == $past(prog_wdata[3:2]))
    else $error("detector field not decoded");
  a_wdg_decode: assert property (
    s_wr_one |=> watchdog_type_select == $past(prog_wdata[1]) && nv_wr_strobe && nv_wr_sel)
    else $error("watchdog type not decoded");
  a_halt_decode: assert property (
    s_wr_one |=> watchdog_halt_reset == $past(prog_wdata[0]))
    else $error("halt reset bit not decoded");
  a_sector_decode: assert property (
    s_wr_zero |=> sector_zero_size == $past(prog_wdata[2]) && !nv_wr_sel)
    else $error("sector size not decoded");
  a_rop_block: assert property (
    flash_write_block == (readout_protect || flash_write_protect))
    else $error("read-out protection does not block writes");
  a_rop_erase_first: assert property (
    ob_reg.state == obcd_pkg::OBCD_RUN && prog_mode && prog_erase && readout_protect && !flash_write_protect
      |=> mem_erase_req && !nv_opt_erase && readout_protect)
    else $error("option erase before memory erase");
  a_erase_wait: assert property (
    mem_erase_req && !mem_erase_done |=> mem_erase_req && !prog_ack)
    else $error("memory erase request dropped early");
  a_wp_locked: assert property (
    flash_write_protect && ob_reg.state == obcd_pkg::OBCD_RUN && prog_mode && (prog_wr || prog_erase)
      |=> prog_refused && !nv_wr_strobe && $stable(ob_reg.cfg0) && $stable(ob_reg.cfg1))
    else $error("write protected bytes changed");
  a_fill_erased: assert property (
    ##1 mem_erase_fill == 8'hff)
    else $error("erased fill value wrong");
  a_load_latch: assert property (
    ob_reg.state == obcd_pkg::OBCD_LOAD |=> ob_reg.cfg0 == $past(nv_byte0) && ob_reg.cfg1 == $past(nv_byte1)
      && config_valid)
    else $error("stored bytes not latched after reset");

endmodule : obcd_option_decoder

`default_nettype wire

// ### dv/obcd_flash_model.sv
// Behavioural model of the non-volatile option byte array and program flash
`timescale 1ns/10ps
`default_nettype none

module obcd_flash_model (
  input  wire logic       sys_clk,
  input  wire logic       nv_wr_strobe,
  input  wire logic       nv_wr_sel,
  input  wire logic [7:0] nv_wr_data,
  input  wire logic       nv_opt_erase,
  input  wire logic       mem_erase_req,
  output logic      [7:0] nv_byte0,
  output logic      [7:0] nv_byte1,
  output logic            mem_erase_done
);
  int unsigned wait_cnt;
  int unsigned wait_len;

  // Contents survive reset, as a real array would
  initial
  begin
    nv_byte0       = obcd_pkg::CFG0_RESET;
    nv_byte1       = obcd_pkg::CFG1_RESET;
    mem_erase_done = 1'b0;
    wait_cnt       = 0;
    wait_len       = 3;
  end

  always @(posedge sys_clk)
  begin
    if (nv_opt_erase)
    begin
      nv_byte0 <= obcd_pkg::CFG0_RESET;
      nv_byte1 <= obcd_pkg::CFG1_RESET;
    end
    else if (nv_wr_strobe && nv_wr_sel)
      nv_byte1 <= nv_wr_data;
    else if (nv_wr_strobe)
      nv_byte0 <= nv_wr_data;
    // Full erase takes a varying time and ends with a one-cycle done pulse
    if (mem_erase_req && !mem_erase_done && wait_cnt >= wait_len)
    begin
      mem_erase_done <= 1'b1;
      wait_cnt       <= 0;
      wait_len       <= $urandom_range(12, 2);
    end
    else
    begin
      mem_erase_done <= 1'b0;
      if (mem_erase_req && !mem_erase_done)
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : obcd_flash_model

`default_nettype wire

// ### dv/obcd_option_decoder_bench.sv
// Self-checking bench for the option byte decoder with a flash array model
`timescale 1ns/10ps
`default_nettype none

module obcd_option_decoder_bench;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       prog_mode = 1'b0;
  logic       prog_rd = 1'b0;
  logic       prog_wr = 1'b0;
  logic       prog_erase = 1'b0;
  logic       prog_sel = 1'b0;
  logic [7:0] prog_wdata = 8'h00;
  logic [7:0] nv_byte0, nv_byte1, prog_rdata, nv_wr_data, mem_erase_fill;
  logic       mem_erase_done, prog_ack, prog_refused, nv_wr_strobe, nv_wr_sel, nv_opt_erase;
  logic       mem_erase_req, config_valid, watchdog_type_select, watchdog_halt_reset;
  logic       sector_zero_size, readout_protect, flash_write_protect, flash_write_block;
  logic [1:0] startup_clock_select, low_voltage_detect_threshold;
  logic [9:0] expq[$];
  logic       erase_seen = 1'b0;
  int         fails = 0;
  int         total_checks = 0;

  obcd_option_decoder obcd_option_decoder_inst (
    .sys_clk(sys_clk), .rst(rst), .prog_mode(prog_mode), .prog_rd(prog_rd), .prog_wr(prog_wr),
    .prog_erase(prog_erase), .prog_sel(prog_sel), .prog_wdata(prog_wdata), .nv_byte0(nv_byte0),
    .nv_byte1(nv_byte1), .mem_erase_done(mem_erase_done), .prog_rdata(prog_rdata), .prog_ack(prog_ack),
    .prog_refused(prog_refused), .nv_wr_strobe(nv_wr_strobe), .nv_wr_sel(nv_wr_sel),
    .nv_wr_data(nv_wr_data), .nv_opt_erase(nv_opt_erase), .mem_erase_req(mem_erase_req),
    .mem_erase_fill(mem_erase_fill), .config_valid(config_valid),
    .startup_clock_select(startup_clock_select), .low_voltage_detect_threshold(low_voltage_detect_threshold),
    .watchdog_type_select(watchdog_type_select), .watchdog_halt_reset(watchdog_halt_reset),
    .sector_zero_size(sector_zero_size), .readout_protect(readout_protect),
    .flash_write_protect(flash_write_protect), .flash_write_block(flash_write_block));

  obcd_flash_model obcd_flash_model_inst (
    .sys_clk(sys_clk), .nv_wr_strobe(nv_wr_strobe), .nv_wr_sel(nv_wr_sel), .nv_wr_data(nv_wr_data),
    .nv_opt_erase(nv_opt_erase), .mem_erase_req(mem_erase_req), .nv_byte0(nv_byte0),
    .nv_byte1(nv_byte1), .mem_erase_done(mem_erase_done));

  always #4 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic fail_msg(input string msg);
    fails++;
    $display("Error at %0t: %s", $time, msg);
  endtask : fail_msg

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
      fail_msg($sformatf("byte %h, expected %h", got, exp));
  endtask : check_byte

  // Expected note: bit 9 refused, bit 8 read with data in 7:0
  task automatic check_resp(input logic [9:0] exp);
    total_checks++;
    if (prog_refused !== exp[9] || prog_ack !== !exp[9] || (exp[8] && prog_rdata !== exp[7:0]))
      fail_msg($sformatf("response ref %b data %h, expected %h", prog_refused, prog_rdata, exp));
  endtask : check_resp

  task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1);
    logic [18:0] got;
    logic [18:0] exp;
    got = {config_valid, startup_clock_select, low_voltage_detect_threshold, watchdog_type_select,
           watchdog_halt_reset, sector_zero_size, readout_protect, flash_write_protect, flash_write_block,
           mem_erase_fill};
    exp = {1'b1, b1[7:6], b1[3:2], b1[1], b1[0], b0[2], b0[1], b0[0], b0[1] | b0[0],
           obcd_pkg::PROG_MEM_ERASED};
    total_checks++;
    if (got !== exp)
      fail_msg($sformatf("config %h, expected %h", got, exp));
  endtask : check_cfg

  // Kind bits are erase, write, read; one-cycle request then bounded wait for the answer, or three idle cycles outside programming mode
  task automatic op(input logic [2:0] kind, input logic sel, input logic [7:0] data, input logic mode,
                    input logic [9:0] exp);
    int n;
    n = 0;
    @(posedge sys_clk);
    prog_mode                        <= mode;
    {prog_erase, prog_wr, prog_rd}   <= kind;
    prog_sel                         <= sel;
    prog_wdata                       <= data;
    if (mode)
      expq.push_back(exp);
    @(posedge sys_clk);
    {prog_erase, prog_wr, prog_rd} <= 3'h0;
    @(negedge sys_clk);
    while (mode && prog_ack !== 1'b1 && prog_refused !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        fail_msg("no answer");
        report_and_stop();
      end
      @(negedge sys_clk);
    end
    if (!mode)
      repeat (3) @(negedge sys_clk);
  endtask : op

  always @(negedge sys_clk)
  begin
    if (mem_erase_req === 1'b1)
      erase_seen = 1'b1;
    if (prog_ack === 1'b1 || prog_refused === 1'b1)
    begin
      if (expq.size() == 0)
        fail_msg("unexpected response");
      else
        check_resp(expq.pop_front());
    end
  end

  initial
  begin
    logic [7:0] b0;
    logic [7:0] b1;
    void'($urandom(34972));
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check_cfg(8'hf0, 8'h2f);
    $display("Test defaults done");
    // Every clock and detector code, random watchdog bits, reserved bits as required
    for (int i = 0; i < 16; i++)
    begin
      b1 = {i[3:2], 2'b10, i[1:0], 2'($urandom)};
      op(3'h2, 1'b1, b1, 1'b1, 10'h000);
      op(3'h1, 1'b1, 8'h00, 1'b1, {2'b01, b1});
      check_cfg(8'hf0, b1);
    end
    b0 = {4'hf, 1'b0, 1'($urandom), 2'b00};
    op(3'h2, 1'b0, b0, 1'b1, 10'h000);
    check_cfg(b0, b1);
    op(3'h2, 1'b0, 8'hf4 ^ b0, 1'b0, 10'h000);
    check_byte(prog_rdata, 8'h00);
    check_cfg(b0, b1);
    op(3'h4, 1'b0, 8'h00, 1'b1, 10'h000);
    check_cfg(8'hf0, 8'h2f);
    @(negedge sys_clk);
    check_byte(nv_byte1, 8'h2f);
    check_byte({7'h00, erase_seen}, 8'h00);
    $display("Test field decode done");
    op(3'h2, 1'b0, 8'hf6, 1'b1, 10'h000);
    check_cfg(8'hf6, 8'h2f);
    op(3'h4, 1'b0, 8'h00, 1'b1, 10'h000);
    check_byte({7'h00, erase_seen}, 8'h01);
    check_cfg(8'hf0, 8'h2f);
    @(negedge sys_clk);
    check_byte(nv_byte0, 8'hf0);
    $display("Test protected erase done");
    op(3'h2, 1'b0, 8'hf1, 1'b1, 10'h000);
    op(3'h2, 1'b1, 8'h23, 1'b1, 10'h200);
    op(3'h4, 1'b0, 8'h00, 1'b1, 10'h200);
    op(3'h1, 1'b0, 8'h00, 1'b1, {2'b01, 8'hf1});
    check_cfg(8'hf1, 8'h2f);
    check_byte(nv_wr_data, 8'hf1);
    check_byte({7'h00, nv_wr_sel}, 8'h00);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check_cfg(8'hf1, 8'h2f);
    $display("Test write lock done");
    report_and_stop();
  end
endmodule : obcd_option_decoder_bench

`default_nettype wire
